/* File: luma_map.svh */
// Offsets, field positions, reset values and timing counts of the luma path.
// Assumes inclusion by bare name; holds definitions only.
`ifndef LUMA_MAP_SVH
`define LUMA_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_NR_CTRL0 6'h23
`define ADDR_NR_CTRL1 6'h24
`define ADDR_NR_CTRL2 6'h25
`define ADDR_GAMMA_BASE 6'h26
`define ADDR_BRIGHT 6'h34
`define GAMMA_REGS 14
`define CURVE_POINTS 7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GAIN_BORDER_LSB 0
`define GAIN_INTERIOR_LSB 4
`define THR_LSB 0
`define BORDER_WIDTH_BIT 6
`define BLOCK_SIZE_BIT 7
`define FILTER_SEL_LSB 0
`define MODE_BIT 3
`define OFFSET_LSB 4

// ----------------------------------------------------------------------
// Reset values and curve anchors
// ----------------------------------------------------------------------
`define NR_CTRL0_RST 8'h00
`define NR_CTRL1_RST 8'h00
`define NR_CTRL2_RST 8'h00
`define GAMMA_STEP 32
`define ANCHOR_LOW 8'h10
`define ANCHOR_HIGH 8'hF0
`define GAIN_PLAIN_MAX 5'h08
`define GAIN_SHARP_MAX 5'h08

// ----------------------------------------------------------------------
// Block geometry and timing counts
// ----------------------------------------------------------------------
`define BLOCK_MASK_LARGE 4'hF
`define BLOCK_MASK_SMALL 4'h7
`define BORDER_HALF_WIDE 4'h2
`define BORDER_HALF_NARROW 4'h1
`define CYC_PER_PIXEL_LOG2 1

`endif

/* File: luma_pkg.sv */
// Types shared by the luma path modules.
// Assumes luma_map.svh supplies all numeric constants.
package luma_pkg;
    // Eight-bit luma sample
    typedef logic [7:0] pix_t;
    // Noise-reduction operating mode
    typedef enum logic {NR_PLAIN, NR_SHARP} nr_mode_e;
    // Active gamma curve
    typedef enum logic {CURVE_A, CURVE_B} curve_sel_e;
endpackage

/* File: luma_stage_if.sv */
// Carrier of the filtered luma stream between noise reduction and gamma.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface luma_stage_if;
    logic valid;          // One-cycle pulse per pixel
    luma_pkg::pix_t luma; // Noise-reduced sample
    modport src (output valid, output luma);
    modport snk (input valid, input luma);
endinterface

/* File: nr_core.sv */
// Noise-reduction datapath: passband filter, coring and gain stage.
// Assumes one pixel strobe every second clock and a border flag per pixel.
`timescale 1ns/1ps
`include "luma_map.svh"
module nr_core (
    input wire logic sys_clk,
    input wire logic rst,
    input wire luma_pkg::pix_t pix_in,
    input wire logic pix_stb,
    input wire logic border_zone,
    input wire logic [2:0] filter_sel,
    input wire luma_pkg::nr_mode_e mode,
    input wire logic [5:0] thr,
    input wire logic [3:0] gain_border,
    input wire logic [3:0] gain_interior,
    luma_stage_if.src out_if
);
    // ------------------------------------------------------------------
    // Tap line and aligned border flags
    // ------------------------------------------------------------------
    luma_pkg::pix_t tap_r [0:8];   // Nine-pixel window, centre at 4
    luma_pkg::pix_t tap_nxt [0:8];
    logic [4:0] bflag_r;           // Border flag delayed to the centre
    logic [4:0] bflag_nxt;
    luma_pkg::pix_t out_r;
    luma_pkg::pix_t out_nxt;
    logic valid_r;
    logic valid_nxt;

    // Window shifts once per pixel, one pixel being two clocks [R2]
    genvar t;
    generate
        for (t = 0; t < 9; t = t + 1) begin : g_tap
            always_comb begin
                if (!pix_stb) begin
                    tap_nxt[t] = tap_r[t];
                end else if (t == 0) begin
                    tap_nxt[t] = pix_in;
                end else begin
                    tap_nxt[t] = tap_r[(t == 0) ? 0 : t - 1];
                end
            end
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    tap_r[t] <= 8'h00;
                end else begin
                    tap_r[t] <= tap_nxt[t];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Filter and coring
    // ------------------------------------------------------------------
    logic signed [10:0] hp;        // Passband content
    logic [9:0] mag;               // Its magnitude
    logic [4:0] gain;              // Clamped gain
    logic signed [16:0] prod;      // Scaled passband content
    logic signed [11:0] res;       // Corrected luma before saturation
    luma_pkg::pix_t lo;
    luma_pkg::pix_t hi;

    // Selector picks span and strength of the high-pass kernel [R3]
    always_comb begin
        case (filter_sel[1:0])
            2'h0: begin lo = tap_r[3]; hi = tap_r[5]; end
            2'h1: begin lo = tap_r[2]; hi = tap_r[6]; end
            2'h2: begin lo = tap_r[1]; hi = tap_r[7]; end
            default: begin lo = tap_r[0]; hi = tap_r[8]; end
        endcase
        hp = (11'sd2 * $signed({3'h0, tap_r[4]})
              - $signed({3'h0, lo}) - $signed({3'h0, hi})) >>> 1;
        if (filter_sel[2]) begin
            hp = hp >>> 1;
        end
        mag = hp[10] ? 10'(-hp) : hp[9:0];
        // Border and interior gains apply by block position [R8]
        gain = {1'b0, bflag_r[4] ? gain_border : gain_interior};
        if (mode == luma_pkg::NR_PLAIN && gain > `GAIN_PLAIN_MAX) begin
            gain = `GAIN_PLAIN_MAX;
        end else if (mode == luma_pkg::NR_SHARP && gain > `GAIN_SHARP_MAX) begin
            gain = `GAIN_SHARP_MAX;
        end
        // Both factors widened first so large content cannot wrap
        prod = 17'(hp) * 17'($signed({1'b0, gain}));
        res = $signed({4'h0, tap_r[4]});
        if (mode == luma_pkg::NR_PLAIN) begin
            // Small content treated as noise and taken away [R4] [R5] [R7]
            if (mag < {4'h0, thr}) begin
                res = res - 12'(prod >>> 3);
            end
        end else begin
            // Large content treated as detail and added [R4] [R6] [R7]
            if (mag > {4'h0, thr}) begin
                res = res + 12'(prod >>> 4);
            end
        end
    end

    // Output register with saturation; border flag pipeline
    always_comb begin
        bflag_nxt = pix_stb ? {bflag_r[3:0], border_zone} : bflag_r;
        valid_nxt = pix_stb;
        out_nxt = out_r;
        if (pix_stb) begin
            if (res < 0) begin
                out_nxt = 8'h00;
            end else if (res > 12'sd255) begin
                out_nxt = 8'hFF;
            end else begin
                out_nxt = res[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bflag_r <= 5'h00;
            valid_r <= 1'b0;
            out_r <= 8'h00;
        end else begin
            bflag_r <= bflag_nxt;
            valid_r <= valid_nxt;
            out_r <= out_nxt;
        end
    end

    assign out_if.valid = valid_r;
    assign out_if.luma = out_r;
endmodule

/* File: gamma_interp.sv */
// Piecewise-linear gamma curve with fixed anchors and seven points.
// Assumes the point set is stable while samples flow.
`timescale 1ns/1ps
`include "luma_map.svh"
module gamma_interp (
    input wire logic sys_clk,
    input wire logic rst,
    luma_stage_if.snk in_if,
    input wire luma_pkg::pix_t pts [0:6],
    output logic [7:0] luma_out,
    output logic luma_out_valid
);
    // ------------------------------------------------------------------
    // Segment lookup and interpolation
    // ------------------------------------------------------------------
    luma_pkg::pix_t x;
    luma_pkg::pix_t y0;
    luma_pkg::pix_t y1;
    logic [4:0] frac;
    logic seg_short;               // 16-wide end segment
    logic pass;                    // Sample sits on a fixed identity part
    logic [2:0] k;
    logic signed [15:0] prod;
    logic signed [10:0] y;
    luma_pkg::pix_t out_r;
    luma_pkg::pix_t out_nxt;
    logic valid_r;
    logic valid_nxt;

    // Points at 32..224, linear between, anchors fixed [R13] [R14] [R15]
    always_comb begin
        x = in_if.luma;
        k = 3'(x[7:5] - 3'h1);
        pass = (x < `ANCHOR_LOW) || (x >= `ANCHOR_HIGH);
        seg_short = 1'b0;
        frac = x[4:0];
        y0 = pts[0];
        y1 = pts[0];
        if (x < 8'h20) begin
            // Between anchor 16 and the first point
            y0 = `ANCHOR_LOW;
            y1 = pts[0];
            seg_short = 1'b1;
            frac = {1'b0, x[3:0]};
        end else if (x >= 8'hE0) begin
            // Between the last point and anchor 240
            y0 = pts[6];
            y1 = `ANCHOR_HIGH;
            seg_short = 1'b1;
            frac = {1'b0, x[3:0]};
        end else begin
            y0 = pts[k];
            y1 = pts[3'(k + 3'h1)];
        end
        // Operands widened first so a steep segment cannot wrap
        prod = 16'($signed({1'b0, y1}) - $signed({1'b0, y0}))
               * 16'($signed({1'b0, frac}));
        y = $signed({3'h0, y0})
            + 11'(seg_short ? (prod >>> 4) : (prod >>> 5));
        if (pass) begin
            out_nxt = x;
        end else if (y < 0) begin
            out_nxt = 8'h00;
        end else if (y > 11'sd255) begin
            out_nxt = 8'hFF;
        end else begin
            out_nxt = y[7:0];
        end
        if (!in_if.valid) begin
            out_nxt = out_r;
        end
        valid_nxt = in_if.valid;
    end

    // Output registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_r <= 8'h00;
            valid_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign luma_out = out_r;
    assign luma_out_valid = valid_r;
endmodule

/* File: luma_noise_gamma_processor.sv */
// Luma post-processing path: noise reduction, gamma and brightness monitor.
// Assumes synchronous pixel inputs, one pixel per two clocks, and a simple
// register port driven by the serial host interface logic.
//
// Function
// R1 - Block size selector picks 16 or 8
// R2 - One pixel counts as two clock cycles
// R3 - Three-bit selector picks passband filter for processing
// R4 - Mode bit picks plain or sharpness mode
// R5 - Plain: subtract scaled sub-threshold content
// R6 - Sharp: add scaled above-threshold content
// R7 - Six-bit absolute threshold, zero to 63
// R8 - Border/interior gains in eighths or sixteenths
// R9 - Border width four or two pixels
// R10 - Four-bit block offset shifts block position
// R11 - Fourteen gamma registers, two seven-point curves
// R12 - Gamma on luma only, one curve active
// R13 - Curve points at 32..224, linear between
// R14 - Points 0, 16, 240, 255 fixed
// R15 - Fixed points output their own position
// R16 - Software keeps point values within 16..240
// R17 - Eight-bit read-only average brightness register
// R18 - Brightness counts active video samples only
// R19 - Brightness updates on vertical sync fall
// R20 - Average is sum over count, held
`timescale 1ns/1ps
`include "luma_map.svh"
module luma_noise_gamma_processor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] luma_in,
    input wire logic luma_valid,
    input wire logic active_video,
    input wire logic line_start,
    input wire logic vsync_n,
    input wire logic gamma_curve_sel,
    output logic [7:0] luma_out,
    output logic luma_out_valid
);
    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [7:0] ctrl0_r;           // Coring gains
    logic [7:0] ctrl0_nxt;
    logic [7:0] ctrl1_r;           // Threshold, border width, block size
    logic [7:0] ctrl1_nxt;
    logic [7:0] ctrl2_r;           // Filter, mode, block offset
    logic [7:0] ctrl2_nxt;
    luma_pkg::pix_t gam_r [0:13];  // Curve A then curve B
    luma_pkg::pix_t gam_nxt [0:13];

    // Host writes to the noise-reduction registers
    always_comb begin
        ctrl0_nxt = ctrl0_r;
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        if (reg_wr) begin
            if (reg_addr == `ADDR_NR_CTRL0) begin
                ctrl0_nxt = reg_wdata;
            end else if (reg_addr == `ADDR_NR_CTRL1) begin
                ctrl1_nxt = reg_wdata;
            end else if (reg_addr == `ADDR_NR_CTRL2) begin
                ctrl2_nxt = reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl0_r <= `NR_CTRL0_RST;
            ctrl1_r <= `NR_CTRL1_RST;
            ctrl2_r <= `NR_CTRL2_RST;
        end else begin
            ctrl0_r <= ctrl0_nxt;
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
        end
    end

    // Gamma point registers, one per entry, reset to a straight line [R11]
    genvar g;
    generate
        for (g = 0; g < `GAMMA_REGS; g = g + 1) begin : g_gam
            localparam logic [5:0] GADDR = 6'(`ADDR_GAMMA_BASE + g);
            localparam logic [7:0] GRST =
                8'((g % `CURVE_POINTS + 1) * `GAMMA_STEP);
            always_comb begin
                if (reg_wr && reg_addr == GADDR) begin
                    gam_nxt[g] = reg_wdata;
                end else begin
                    gam_nxt[g] = gam_r[g];
                end
            end
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    gam_r[g] <= GRST;
                end else begin
                    gam_r[g] <= gam_nxt[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    logic [3:0] gain_border;
    logic [3:0] gain_interior;
    logic [5:0] thr;
    logic border_wide;
    logic block_large;
    logic [2:0] filter_sel;
    luma_pkg::nr_mode_e nr_mode;
    logic [3:0] block_offset;

    assign gain_border = ctrl0_r[`GAIN_BORDER_LSB +: 4];
    assign gain_interior = ctrl0_r[`GAIN_INTERIOR_LSB +: 4];
    assign thr = ctrl1_r[`THR_LSB +: 6];
    assign border_wide = ctrl1_r[`BORDER_WIDTH_BIT];
    assign block_large = ctrl1_r[`BLOCK_SIZE_BIT];
    assign filter_sel = ctrl2_r[`FILTER_SEL_LSB +: 3];
    assign nr_mode = luma_pkg::nr_mode_e'(ctrl2_r[`MODE_BIT]);
    assign block_offset = ctrl2_r[`OFFSET_LSB +: 4];

    // ------------------------------------------------------------------
    // Block position tracking
    // ------------------------------------------------------------------
    logic [11:0] col_cyc_r;        // Clocks since line start
    logic [11:0] col_cyc_nxt;
    logic [9:0] line_r;            // Lines since vertical sync
    logic [9:0] line_nxt;
    logic vsync_d_r;               // Previous vertical sync level
    logic vsync_fall;
    logic [10:0] pix_idx;
    logic [3:0] blk_mask;
    logic [3:0] half_w;
    logic [3:0] hpos;
    logic [3:0] vpos;
    logic h_border;
    logic v_border;
    logic border_zone;

    assign vsync_fall = vsync_d_r && !vsync_n;

    // Line and column counters
    always_comb begin
        col_cyc_nxt = line_start ? 12'h000 : 12'(col_cyc_r + 12'h001);
        line_nxt = line_r;
        if (vsync_fall) begin
            line_nxt = 10'h000;
        end else if (line_start) begin
            line_nxt = 10'(line_r + 10'h001);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            col_cyc_r <= 12'h000;
            line_r <= 10'h000;
            vsync_d_r <= 1'b1;
        end else begin
            col_cyc_r <= col_cyc_nxt;
            line_r <= line_nxt;
            vsync_d_r <= vsync_n;
        end
    end

    // Border zone of the current pixel within its block
    always_comb begin
        // Pixel index is the clock count over two [R2]
        pix_idx = col_cyc_r[11:`CYC_PER_PIXEL_LOG2];
        // Block of 16 or 8 pixels each way [R1]
        blk_mask = block_large ? `BLOCK_MASK_LARGE : `BLOCK_MASK_SMALL;
        // Transition area of four or two pixels across the edge [R9]
        half_w = border_wide ? `BORDER_HALF_WIDE : `BORDER_HALF_NARROW;
        // Offset slides the data against fixed gain positions [R10]
        hpos = 4'(pix_idx[3:0] + block_offset) & blk_mask;
        vpos = line_r[3:0] & blk_mask;
        h_border = (hpos < half_w) || (hpos > 4'(blk_mask - half_w));
        v_border = (vpos < half_w) || (vpos > 4'(blk_mask - half_w));
        border_zone = h_border || v_border;
    end

    // ------------------------------------------------------------------
    // Noise reduction and gamma stages
    // ------------------------------------------------------------------
    luma_stage_if stage_if ();
    luma_pkg::pix_t pts [0:6];

    nr_core u_nr (
        .sys_clk(sys_clk),
        .rst(rst),
        .pix_in(luma_in),
        .pix_stb(luma_valid),
        .border_zone(border_zone),
        .filter_sel(filter_sel),
        .mode(nr_mode),
        .thr(thr),
        .gain_border(gain_border),
        .gain_interior(gain_interior),
        .out_if(stage_if.src)
    );

    // Only one curve feeds the interpolator at any time [R12]
    genvar p;
    generate
        for (p = 0; p < `CURVE_POINTS; p = p + 1) begin : g_pts
            assign pts[p] = (gamma_curve_sel == luma_pkg::CURVE_B)
                            ? gam_r[p + `CURVE_POINTS] : gam_r[p];
        end
    endgenerate

    // Gamma acts on the luma stream alone [R12]
    gamma_interp u_gamma (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_if(stage_if.snk),
        .pts(pts),
        .luma_out(luma_out),
        .luma_out_valid(luma_out_valid)
    );

    // ------------------------------------------------------------------
    // Average brightness monitor
    // ------------------------------------------------------------------
    logic [26:0] acc_r;            // Active-area luma sum
    logic [26:0] acc_nxt;
    logic [19:0] cnt_r;            // Active-area sample count
    logic [19:0] cnt_nxt;
    logic [7:0] bright_r;          // Held average
    logic [7:0] bright_nxt;
    logic [26:0] quot;
    logic take;

    // Sum active samples, publish on vertical sync fall
    always_comb begin
        // Blanking samples are left out [R18]
        take = luma_valid && active_video;
        quot = acc_r / {7'h00, cnt_r};
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        bright_nxt = bright_r;
        if (vsync_fall) begin
            // Truncated quotient held until the next fall [R19] [R20]
            if (cnt_r != 20'h00000) begin
                bright_nxt = quot[7:0];
            end
            // A sample in the same cycle starts the new field
            acc_nxt = take ? {19'h00000, luma_in} : 27'h0000000;
            cnt_nxt = take ? 20'h00001 : 20'h00000;
        end else if (take) begin
            acc_nxt = 27'(acc_r + {19'h00000, luma_in});
            cnt_nxt = 20'(cnt_r + 20'h00001);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_r <= 27'h0000000;
            cnt_r <= 20'h00000;
            bright_r <= 8'h00;
        end else begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
            bright_r <= bright_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    logic [7:0] rdata_nxt;
    logic [3:0] gidx;

    // Read data one clock after the read strobe; unmapped reads give zero
    always_comb begin
        gidx = 4'(reg_addr - `ADDR_GAMMA_BASE);
        rdata_nxt = 8'h00;
        if (reg_addr == `ADDR_NR_CTRL0) begin
            rdata_nxt = ctrl0_r;
        end else if (reg_addr == `ADDR_NR_CTRL1) begin
            rdata_nxt = ctrl1_r;
        end else if (reg_addr == `ADDR_NR_CTRL2) begin
            rdata_nxt = ctrl2_r;
        end else if (reg_addr >= `ADDR_GAMMA_BASE &&
                     reg_addr < 6'(`ADDR_GAMMA_BASE + `GAMMA_REGS)) begin
            rdata_nxt = gam_r[gidx];
        end else if (reg_addr == `ADDR_BRIGHT) begin
            // Read-only average, writes there are ignored [R17]
            rdata_nxt = bright_r;
        end
        if (!reg_rd) begin
            rdata_nxt = reg_rdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= rdata_nxt;
            reg_rvalid <= reg_rd;
        end
    end
endmodule

/* File: luma_path_checker.sv */
// Checker watching the ports of the luma path top module.
// Assumes it is bound onto luma_noise_gamma_processor.
`timescale 1ns/1ps
module luma_path_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic luma_valid,
    input wire logic [7:0] luma_out,
    input wire logic luma_out_valid
);
    // ------------------------------------------------------------
    // Register port and pixel stream timing
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_read_answered: assert property (
        reg_rd |=> reg_rvalid) else $error("read not answered");
    chk_answer_cause: assert property (
        reg_rvalid |-> $past(reg_rd)) else $error("stray read answer");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr == 6'h3F |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_held: assert property (
        !reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
    chk_out_latency: assert property (
        luma_valid |-> ##2 luma_out_valid) else $error("output late");
    chk_out_cause: assert property (
        luma_out_valid |-> $past(luma_valid, 2)) else $error("stray output");
    chk_out_pulse: assert property (
        luma_out_valid |=> !luma_out_valid) else $error("output too long");
    chk_out_held: assert property (
        !luma_out_valid |-> $stable(luma_out)) else $error("output moved");
endmodule
bind luma_noise_gamma_processor luma_path_checker luma_path_checker_i (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .luma_valid(luma_valid), .luma_out(luma_out),
    .luma_out_valid(luma_out_valid));

/* File: video_source.sv */
// Upstream pixel source model: one pixel every second clock.
// Assumes pix and act are set by the bench between edges.
`timescale 1ns/1ps
module video_source (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] pix,
    input wire logic act,
    output logic [7:0] luma_in,
    output logic luma_valid,
    output logic active_video,
    output logic line_start
);
    logic ph_r; // Pixel phase
    // ------------------------------------------------------------
    // Strobe every second clock, idle data toggles
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ph_r <= 1'b0;
            luma_valid <= 1'b0;
            luma_in <= 8'h00;
            active_video <= 1'b0;
            line_start <= 1'b0;
        end else begin
            ph_r <= ~ph_r;
            luma_valid <= ~ph_r;
            luma_in <= ph_r ? ~luma_in : pix;
            active_video <= act;
            line_start <= 1'b0;
        end
    end
endmodule

/* File: luma_noise_gamma_processor_test.sv */
// Self-checking bench of the luma path: registers, gamma, brightness.
// Assumes video_source feeds pixels and the checker is bound.
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
    errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module luma_noise_gamma_processor_test;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, vsync_n = 1;
    logic sel = 0, act = 1, luma_valid, active_video, line_start;
    logic reg_rvalid, luma_out_valid;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, pix = 8'h00, luma_in;
    logic [7:0] reg_rdata, luma_out;
    int errors = 0, total_checks = 0;
    always #50 sys_clk = ~sys_clk; // 10 MHz
    video_source video_source_i (.sys_clk(sys_clk), .rst(rst), .pix(pix),
        .act(act), .luma_in(luma_in), .luma_valid(luma_valid),
        .active_video(active_video), .line_start(line_start));
    luma_noise_gamma_processor luma_noise_gamma_processor_i (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .luma_in(luma_in),
        .luma_valid(luma_valid), .active_video(active_video),
        .line_start(line_start), .vsync_n(vsync_n),
        .gamma_curve_sel(sel), .luma_out(luma_out),
        .luma_out_valid(luma_out_valid));
    // ------------------------------------------------------------
    // Register access and stream tasks
    // ------------------------------------------------------------
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(posedge sys_clk) #1 reg_wr = 0;
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge sys_clk) #1 reg_addr = a;
        reg_rd = 1;
        @(posedge sys_clk) #1 reg_rd = 0;
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    // Constant pixels fill the window, so the filter passes them intact
    task px(input logic [7:0] v, input logic [7:0] e);
        @(posedge sys_clk) #1 pix = v;
        repeat (30) @(posedge sys_clk);
        #1 `CHK("luma_out", e, luma_out)
    endtask
    task fall();
        @(posedge sys_clk) #1 vsync_n = 0;
        repeat (3) @(posedge sys_clk);
        #1 vsync_n = 1;
    endtask
    task summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst = 0;
        rd(6'h23, 8'h00);
        rd(6'h26, 8'h20);
        rd(6'h2D, 8'h20);
        wr(6'h24, 8'hBF);
        rd(6'h24, 8'hBF);
        rd(6'h3F, 8'h00);
        wr(6'h34, 8'h5A);
        rd(6'h34, 8'h00);
        px(8'd100, 8'd100);
        wr(6'h28, 8'd150); // Within the sixteen to 240 span
        rd(6'h28, 8'd150);
        px(8'd96, 8'd150);
        px(8'd80, 8'd107);
        px(8'd250, 8'd250);
        px(8'd8, 8'd8);
        sel = 1;
        px(8'd96, 8'd96);
        // Sharpness mode, full gains: a flat field gets no boost
        wr(6'h23, 8'hFF);
        wr(6'h25, 8'h08);
        px(8'd96, 8'd96);
        fall();
        px(8'd96, 8'd96);
        act = 0;
        px(8'd200, 8'd200);
        fall();
        rd(6'h34, 8'd96);
        // New level set with the gate so no stale sample is summed
        pix = 8'd40;
        act = 1;
        px(8'd40, 8'd40);
        rd(6'h34, 8'd96);
        fall();
        rd(6'h34, 8'd40);
        summarize();
    end
    initial begin
        #3000000;
        errors++;
        summarize();
    end
endmodule
